// ### eas_pkg.sv
// Purpose: shared constants and types of the port 2 eee status block
// Assumes: ahb-lite data 32 bits, each register one aligned word
// Notes: register contents sit in the low bits, upper bits read zero
package eas_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (low 12 bits of haddr)
  // ----------------------------------------------------------------
  localparam logic [11:0] EAS_ADDR_STAT = 12'h0f0;
  localparam logic [11:0] EAS_ADDR_CTRL = 12'h0f4;
  localparam logic [11:0] EAS_ADDR_IRQ_STAT = 12'h100;
  localparam logic [11:0] EAS_ADDR_IRQ_CLR = 12'h104;
  localparam logic [11:0] EAS_ADDR_IRQ_EN = 12'h108;
  localparam int EAS_ADDR_W = 12;

  // ----------------------------------------------------------------
  // status and control register field positions
  // ----------------------------------------------------------------
  localparam int EAS_B_RSV15 = 15;
  localparam int EAS_B_HW_EEE = 14;
  localparam int EAS_B_TX_LAT = 13;
  localparam int EAS_B_TX_LIVE = 12;
  localparam int EAS_B_RX_LAT = 11;
  localparam int EAS_B_RX_LIVE = 10;
  localparam int EAS_B_RSV9 = 9;
  localparam int EAS_B_RSV8 = 8;
  localparam int EAS_B_NP_LOC_ABLE = 6;
  localparam int EAS_B_NP_LOC = 5;
  localparam int EAS_B_PD_FAULT = 4;
  localparam int EAS_B_LP_NP = 3;
  localparam int EAS_B_NP_ABLE = 2;
  localparam int EAS_B_PAGE = 1;
  localparam int EAS_B_LP_AN = 0;
  localparam int EAS_B_NP_EN = 0;

  // ----------------------------------------------------------------
  // reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic EAS_RST_RSV15 = 1'b1;
  localparam logic [1:0] EAS_RST_RSV98 = 2'h0;
  localparam logic EAS_RST_NP_EN = 1'b1;
  localparam logic EAS_NP_LOC_ABLE = 1'b1;
  localparam logic EAS_NP_LOC_ALT = 1'b1;
  localparam logic EAS_NP_ABLE_LOCAL = 1'b1;
  localparam logic [31:0] EAS_RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // interrupt event bits
  // ----------------------------------------------------------------
  localparam int EAS_IRQ_W = 4;
  localparam int EAS_EV_TX_LPI = 0;
  localparam int EAS_EV_RX_LPI = 1;
  localparam int EAS_EV_PD_FAULT = 2;
  localparam int EAS_EV_PAGE = 3;

  // ----------------------------------------------------------------
  // phy side status levels
  // ----------------------------------------------------------------
  typedef struct packed {
    logic eee_agreed;
    logic tx_lpi;
    logic rx_lpi;
    logic pd_fault;
    logic page_rcvd;
    logic lp_np_able;
    logic lp_an_able;
  } eas_phy_t;
  localparam int EAS_PHY_W = $bits(eas_phy_t);

endpackage : eas_pkg

// ### eas_sync.sv
// Purpose: two-flop synchroniser for phy side levels
// Assumes: inputs are levels held for at least two hclk cycles
// Notes: first stage feeds only the second stage
module eas_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // per bit stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_r;
      logic meta_nxt;
      logic sync_r;
      logic sync_nxt;
      always_comb
      begin
        meta_nxt = d_i[i];
        sync_nxt = meta_r;
      end
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end
        else
        begin
          meta_r <= meta_nxt;
          sync_r <= sync_nxt;
        end
      end
      assign q_o[i] = sync_r;
    end
  endgenerate

endmodule : eas_sync

// ### eas_irq.sv
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: clear and enable strobes are one-cycle write pulses
// Notes: an event in the clear cycle keeps its bit set
module eas_irq (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // events and software access
  input wire logic [eas_pkg::EAS_IRQ_W-1:0] evt_i,
  input wire logic clr_we_i,
  input wire logic en_we_i,
  input wire logic [eas_pkg::EAS_IRQ_W-1:0] wdata_i,
  // state
  output logic [eas_pkg::EAS_IRQ_W-1:0] stat_o,
  output logic [eas_pkg::EAS_IRQ_W-1:0] en_o,
  output logic irq_o
);
  import eas_pkg::*;

  logic [EAS_IRQ_W-1:0] stat_r;
  logic [EAS_IRQ_W-1:0] stat_nxt;
  logic [EAS_IRQ_W-1:0] en_r;
  logic [EAS_IRQ_W-1:0] en_nxt;
  logic irq_r;
  logic irq_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    stat_nxt = stat_r & ~(clr_we_i ? wdata_i : '0);
    stat_nxt = stat_nxt | evt_i;
    en_nxt = en_we_i ? wdata_i : en_r;
    irq_nxt = |(stat_nxt & en_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_r <= '0;
      en_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign stat_o = stat_r;
  assign en_o = en_r;
  assign irq_o = irq_r;

endmodule : eas_irq

// ### eas_top.sv
// Purpose: port 2 eee status and auto-negotiation expansion register
// Assumes: phy status levels are asynchronous and held >= 2 cycles
// Notes: ahb-lite slave, writes zero wait, reads one wait state
//
// Functional notes
// - bit 14 shows eee enabled by next-page exchange, read-only, reset 0
// - bit 13 latches high when transmit pcs sees lpi, reset 0
// - lpi latches stay set until software writes one to them
// - bit 12 follows live transmit lpi, no latching
// - bit 11 latches high when receive pcs sees lpi, reset 0
// - bit 10 follows live receive lpi, no latching
// - bit 6 reads one: next-page location given by bits 6:5
// - bit 5 reads one: partner next pages go to alternate register
// - bit 4 latches parallel detection fault, cleared by read, reset 0
// - bit 3 shows partner next-page ability, reset 0
// - bit 2 reads one: local device is next-page able
// - bit 1 latches a newly received page, reset 0
// - bit 0 shows partner auto-negotiation ability, reset 0
// - next-page enable cleared keeps hardware eee status at 0
module eas_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // phy side levels
  input wire eas_pkg::eas_phy_t phy_i,
  // interrupt
  output logic irq
);
  import eas_pkg::*;

  // ----------------------------------------------------------------
  // synchronised phy levels
  // ----------------------------------------------------------------
  logic [EAS_PHY_W-1:0] phy_v;
  eas_phy_t phy_s;

  eas_sync #(
    .W(EAS_PHY_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d_i(phy_i),
    .q_o(phy_v)
  );

  assign phy_s = phy_v;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic rd_pend_r;
  logic rd_pend_nxt;
  logic [EAS_ADDR_W-1:0] addr_r;
  logic [EAS_ADDR_W-1:0] addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  logic hreadyout_nxt;
  logic [31:0] rd_mux;
  logic wr_stat;
  logic wr_ctrl;
  logic wr_iclr;
  logic wr_ien;
  logic rd_stat;

  // hsize is not checked: only whole-word singles are expected
  assign acc = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;
  assign wr_acc = acc & hwrite;
  assign wr_stat = wr_pend_r && (addr_r == EAS_ADDR_STAT);
  assign wr_ctrl = wr_pend_r && (addr_r == EAS_ADDR_CTRL);
  assign wr_iclr = wr_pend_r && (addr_r == EAS_ADDR_IRQ_CLR);
  assign wr_ien = wr_pend_r && (addr_r == EAS_ADDR_IRQ_EN);
  assign rd_stat = rd_pend_r && (addr_r == EAS_ADDR_STAT);

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  logic rsv15_r;
  logic rsv15_nxt;
  logic [1:0] rsv98_r;
  logic [1:0] rsv98_nxt;
  logic np_en_r;
  logic np_en_nxt;
  logic eee_en_r;
  logic eee_en_nxt;
  logic tx_lat_r;
  logic tx_lat_nxt;
  logic rx_lat_r;
  logic rx_lat_nxt;
  logic tx_live_r;
  logic tx_live_nxt;
  logic rx_live_r;
  logic rx_live_nxt;
  logic pd_lat_r;
  logic pd_lat_nxt;
  logic pg_lat_r;
  logic pg_lat_nxt;
  logic lp_np_r;
  logic lp_np_nxt;
  logic lp_an_r;
  logic lp_an_nxt;
  logic [15:0] stat_word;

  always_comb
  begin
    stat_word = 16'h0000;
    stat_word[EAS_B_RSV15] = rsv15_r;
    stat_word[EAS_B_HW_EEE] = eee_en_r;
    stat_word[EAS_B_TX_LAT] = tx_lat_r;
    stat_word[EAS_B_TX_LIVE] = tx_live_r;
    stat_word[EAS_B_RX_LAT] = rx_lat_r;
    stat_word[EAS_B_RX_LIVE] = rx_live_r;
    stat_word[EAS_B_RSV9:EAS_B_RSV8] = rsv98_r;
    stat_word[EAS_B_NP_LOC_ABLE] = EAS_NP_LOC_ABLE;
    stat_word[EAS_B_NP_LOC] = EAS_NP_LOC_ALT;
    stat_word[EAS_B_PD_FAULT] = pd_lat_r;
    stat_word[EAS_B_LP_NP] = lp_np_r;
    stat_word[EAS_B_NP_ABLE] = EAS_NP_ABLE_LOCAL;
    stat_word[EAS_B_PAGE] = pg_lat_r;
    stat_word[EAS_B_LP_AN] = lp_an_r;
  end

  // ----------------------------------------------------------------
  // interrupt block
  // ----------------------------------------------------------------
  logic [EAS_IRQ_W-1:0] evt;
  logic [EAS_IRQ_W-1:0] irq_stat;
  logic [EAS_IRQ_W-1:0] irq_en;
  logic irq_w;

  always_comb
  begin
    evt = '0;
    evt[EAS_EV_TX_LPI] = phy_s.tx_lpi;
    evt[EAS_EV_RX_LPI] = phy_s.rx_lpi;
    evt[EAS_EV_PD_FAULT] = phy_s.pd_fault;
    evt[EAS_EV_PAGE] = phy_s.page_rcvd;
  end

  eas_irq u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .evt_i(evt),
    .clr_we_i(wr_iclr),
    .en_we_i(wr_ien),
    .wdata_i(hwdata[EAS_IRQ_W-1:0]),
    .stat_o(irq_stat),
    .en_o(irq_en),
    .irq_o(irq_w)
  );

  assign irq = irq_w;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (addr_r)
      EAS_ADDR_STAT: rd_mux = {16'h0000, stat_word};
      EAS_ADDR_CTRL: rd_mux = {31'h0000_0000, np_en_r};
      EAS_ADDR_IRQ_STAT: rd_mux = {{(32-EAS_IRQ_W){1'b0}}, irq_stat};
      EAS_ADDR_IRQ_EN: rd_mux = {{(32-EAS_IRQ_W){1'b0}}, irq_en};
      default: rd_mux = EAS_RD_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // bus next state
  // ----------------------------------------------------------------
  // one wait state on reads lets a write in flight land first
  always_comb
  begin
    wr_pend_nxt = wr_acc;
    rd_pend_nxt = rd_acc;
    addr_nxt = acc ? haddr[EAS_ADDR_W-1:0] : addr_r;
    hreadyout_nxt = ~rd_acc;
    hrdata_nxt = rd_pend_r ? rd_mux : hrdata_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= '0;
      hreadyout_r <= 1'b1;
      hrdata_r <= EAS_RD_ZERO;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r <= addr_nxt;
      hreadyout_r <= hreadyout_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // field next state
  // ----------------------------------------------------------------
  // latch sets win over a clear in the same cycle
  always_comb
  begin
    np_en_nxt = wr_ctrl ? hwdata[EAS_B_NP_EN] : np_en_r;
    eee_en_nxt = np_en_r & phy_s.eee_agreed;
    tx_live_nxt = phy_s.tx_lpi;
    rx_live_nxt = phy_s.rx_lpi;
    tx_lat_nxt = tx_lat_r & ~(wr_stat & hwdata[EAS_B_TX_LAT]);
    tx_lat_nxt = tx_lat_nxt | phy_s.tx_lpi;
    rx_lat_nxt = rx_lat_r & ~(wr_stat & hwdata[EAS_B_RX_LAT]);
    rx_lat_nxt = rx_lat_nxt | phy_s.rx_lpi;
    pd_lat_nxt = (pd_lat_r & ~rd_stat) | phy_s.pd_fault;
    pg_lat_nxt = (pg_lat_r & ~rd_stat) | phy_s.page_rcvd;
    lp_np_nxt = phy_s.lp_np_able;
    lp_an_nxt = phy_s.lp_an_able;
    rsv15_nxt = wr_stat ? hwdata[EAS_B_RSV15] : rsv15_r;
    rsv98_nxt = wr_stat ? hwdata[EAS_B_RSV9:EAS_B_RSV8] : rsv98_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      np_en_r <= EAS_RST_NP_EN;
      eee_en_r <= 1'b0;
      tx_live_r <= 1'b0;
      rx_live_r <= 1'b0;
      tx_lat_r <= 1'b0;
      rx_lat_r <= 1'b0;
      pd_lat_r <= 1'b0;
      pg_lat_r <= 1'b0;
      lp_np_r <= 1'b0;
      lp_an_r <= 1'b0;
      rsv15_r <= EAS_RST_RSV15;
      rsv98_r <= EAS_RST_RSV98;
    end
    else
    begin
      np_en_r <= np_en_nxt;
      eee_en_r <= eee_en_nxt;
      tx_live_r <= tx_live_nxt;
      rx_live_r <= rx_live_nxt;
      tx_lat_r <= tx_lat_nxt;
      rx_lat_r <= rx_lat_nxt;
      pd_lat_r <= pd_lat_nxt;
      pg_lat_r <= pg_lat_nxt;
      lp_np_r <= lp_np_nxt;
      lp_an_r <= lp_an_nxt;
      rsv15_r <= rsv15_nxt;
      rsv98_r <= rsv98_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_eee_gate;
    !np_en_r |=> !eee_en_r;
  endproperty
  a_eee_gate: assert property (p_eee_gate)
    else $error("eee status set with next page disabled");

  property p_eee_on;
    np_en_r && phy_s.eee_agreed |=> eee_en_r;
  endproperty
  a_eee_on: assert property (p_eee_on)
    else $error("eee status missing");

  property p_tx_set;
    phy_s.tx_lpi |=> tx_lat_r;
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("tx lpi latch not set");

  property p_lat_hold;
    tx_lat_r && !(wr_stat && hwdata[EAS_B_TX_LAT]) |=> tx_lat_r;
  endproperty
  a_lat_hold: assert property (p_lat_hold)
    else $error("tx lpi latch lost without clear");

  property p_tx_live;
    phy_s.tx_lpi ##1 !phy_s.tx_lpi |=> !tx_live_r;
  endproperty
  a_tx_live: assert property (p_tx_live)
    else $error("tx lpi live bit latched");

  property p_rx_set;
    phy_s.rx_lpi |=> rx_lat_r && rx_live_r;
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("rx lpi bits not set");

  property p_rx_live;
    !phy_s.rx_lpi [*2] |-> !rx_live_r;
  endproperty
  a_rx_live: assert property (p_rx_live)
    else $error("rx lpi live bit stuck");

  property p_fixed;
    rd_stat |=> hrdata_r[EAS_B_NP_LOC_ABLE] && hrdata_r[EAS_B_NP_LOC]
      && hrdata_r[EAS_B_NP_ABLE];
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed next page bits wrong");

  property p_pd_clr;
    rd_stat && !phy_s.pd_fault |=> !pd_lat_r;
  endproperty
  a_pd_clr: assert property (p_pd_clr)
    else $error("fault latch not cleared by read");

  property p_lp_np;
    rd_stat |=> hrdata_r[EAS_B_LP_NP] == $past(lp_np_r);
  endproperty
  a_lp_np: assert property (p_lp_np)
    else $error("partner next page bit misread");

  property p_pg_clr;
    rd_stat && !phy_s.page_rcvd |=> !pg_lat_r;
  endproperty
  a_pg_clr: assert property (p_pg_clr)
    else $error("page latch not cleared by read");

  property p_rsv_wr;
    wr_stat |=> rsv15_r == $past(hwdata[EAS_B_RSV15]);
  endproperty
  a_rsv_wr: assert property (p_rsv_wr)
    else $error("reserved bit write not stored");

  property p_rd_wait;
    rd_acc |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");

  c_rd_stat: cover property (rd_stat ##1 hrdata_r[EAS_B_PAGE]);
  c_tx_clr: cover property (tx_lat_r ##1 !tx_lat_r);
  c_eee_on: cover property (!eee_en_r ##1 eee_en_r);
  c_irq: cover property (!irq ##1 irq);

endmodule : eas_top

// ### eas_phy_model.sv
// Purpose: far side model that drives the phy status levels
// Assumes: the bench asks for levels on req_i, changed after a clock edge
// Notes: each level is held two edges at least, so short asks are stretched
module eas_phy_model (
  // clock
  input wire logic hclk,
  // request and pins
  input wire eas_pkg::eas_phy_t req_i,
  output eas_pkg::eas_phy_t phy_o
);
  import eas_pkg::*;

  // ----------------------------------------------------------------
  // level driver
  // ----------------------------------------------------------------
  logic age_r;
  initial phy_o = '0;
  initial age_r = 1'b0;
  // a pulse under two cycles may be lost by the sync stage, so never make one
  always @(posedge hclk)
  begin
    if (req_i != phy_o && age_r)
    begin
      phy_o <= req_i;
      age_r <= 1'b0;
    end
    else
      age_r <= 1'b1;
  end
endmodule : eas_phy_model

// ### eas_top_bench.sv
// Purpose: self-checking bench of the port 2 eee status register
// Assumes: single ahb-lite slave, hready tied to hreadyout
// Notes: phy levels reach the register some edges late, so waits are generous
module eas_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import eas_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  eas_phy_t req, phy;
  int n_mismatch, total_checks;
  logic [15:0] lat, live;

  always #5 hclk = ~hclk;

  eas_phy_model u_eas_phy_model (.hclk(hclk), .req_i(req), .phy_o(phy));

  eas_top u_eas_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .phy_i(phy), .irq(irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bounded wait for hready high at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_mismatch++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step

  // expected status: fixed ones of bits 6, 5, 2 and stored bit 15 added
  function automatic logic [31:0] st(input logic [15:0] v);
    st = {16'h0, v | 16'h8064};
  endfunction : st

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    req = '0;
    n_mismatch = 0;
    total_checks = 0;
    r = $urandom(32'h673a386d);
    step(10);
    hresetn <= 1'b1;
    step(1);
    rdchk("stat_rst", EAS_ADDR_STAT, 32'h8064);
    rdchk("ctrl_rst", EAS_ADDR_CTRL, 32'h1);
    rdchk("irq_rst", EAS_ADDR_IRQ_STAT, 32'h0);
    bus(1'b1, 12'h0fc, 32'hffff_ffff);
    rdchk("unmapped", 12'h0fc, 32'h0);
    // reserved bits stored, read-only bits ignore writes
    bus(1'b1, EAS_ADDR_STAT, 32'h5367);
    rdchk("stat_rsv", EAS_ADDR_STAT, 32'h0364);
    bus(1'b1, EAS_ADDR_STAT, 32'h8000);
    rdchk("stat_rsv2", EAS_ADDR_STAT, st(16'h0));
    // lpi latches and live bits, transmit then receive
    for (int i = 0; i < 2; i++)
    begin
      lat = i ? 16'h0800 : 16'h2000;
      live = i ? 16'h0400 : 16'h1000;
      if (i)
        req.rx_lpi <= 1'b1;
      else
        req.tx_lpi <= 1'b1;
      step(8);
      rdchk("lpi_on", EAS_ADDR_STAT, st(lat | live));
      rdchk("lpi_read", EAS_ADDR_STAT, st(lat | live));
      req <= '0;
      step(8);
      rdchk("lpi_off", EAS_ADDR_STAT, st(lat));
      // ones on the live bit and the other latch only, bit 15 kept high
      bus(1'b1, EAS_ADDR_STAT, {16'h0, 16'h8000 | live | (lat ^ 16'h2800)});
      rdchk("lpi_keep", EAS_ADDR_STAT, st(lat));
      bus(1'b1, EAS_ADDR_STAT, {16'h0, lat | 16'h8000});
      rdchk("lpi_clr", EAS_ADDR_STAT, st(16'h0));
    end
    // read-cleared latches: parallel fault then page received
    for (int i = 0; i < 2; i++)
    begin
      lat = i ? 16'h0002 : 16'h0010;
      if (i)
        req.page_rcvd <= 1'b1;
      else
        req.pd_fault <= 1'b1;
      step(8);
      req <= '0;
      step(8);
      rdchk("rc_set", EAS_ADDR_STAT, st(lat));
      rdchk("rc_clr", EAS_ADDR_STAT, st(16'h0));
    end
    // eee status gated by next-page enable
    req.eee_agreed <= 1'b1;
    step(8);
    rdchk("eee_on", EAS_ADDR_STAT, st(16'h4000));
    bus(1'b1, EAS_ADDR_CTRL, 32'h0);
    step(6);
    rdchk("eee_np_off", EAS_ADDR_STAT, st(16'h0));
    rdchk("ctrl_wr", EAS_ADDR_CTRL, 32'h0);
    bus(1'b1, EAS_ADDR_CTRL, 32'h1);
    step(6);
    rdchk("eee_np_on", EAS_ADDR_STAT, st(16'h4000));
    // random agreement and partner levels on the non-latched bits 14, 3 and 0
    for (int k = 0; k < 20; k++)
    begin
      r = $urandom();
      req.eee_agreed <= r[0];
      req.lp_np_able <= r[1];
      req.lp_an_able <= r[2];
      step(8);
      rdchk("live_rnd", EAS_ADDR_STAT, st({1'b0, r[0], 10'h0, r[1], 2'h0, r[2]}));
    end
    req <= '0;
    // interrupt: raise, clear, mask
    // earlier scenarios left sticky events behind, drop them first
    bus(1'b1, EAS_ADDR_IRQ_CLR, 32'hf);
    bus(1'b1, EAS_ADDR_IRQ_EN, 32'hf);
    rdchk("irq_en", EAS_ADDR_IRQ_EN, 32'hf);
    chk("irq_idle", 32'h0, {31'h0, irq});
    req.pd_fault <= 1'b1;
    step(8);
    chk("irq_hi", 32'h1, {31'h0, irq});
    req <= '0;
    step(8);
    rdchk("irq_stat", EAS_ADDR_IRQ_STAT, 32'h4);
    rdchk("irq_clr_rd", EAS_ADDR_IRQ_CLR, 32'h0);
    bus(1'b1, EAS_ADDR_IRQ_CLR, 32'h4);
    rdchk("irq_stat_clr", EAS_ADDR_IRQ_STAT, 32'h0);
    chk("irq_lo", 32'h0, {31'h0, irq});
    bus(1'b1, EAS_ADDR_IRQ_EN, 32'h0);
    req.tx_lpi <= 1'b1;
    step(8);
    req <= '0;
    step(8);
    chk("irq_mask", 32'h0, {31'h0, irq});
    rdchk("irq_stat_m", EAS_ADDR_IRQ_STAT, 32'h1);
    bus(1'b1, EAS_ADDR_IRQ_EN, 32'h1);
    step(2);
    chk("irq_unmask", 32'h1, {31'h0, irq});
    wrap_up();
  end
endmodule : eas_top_bench
